// [spir_pkg.sv]
package spir_pkg;
	// Command selectors
	localparam logic [7:0] PROTO_INFO = 8'h00;
	localparam logic [15:0] SPEC_LIST = 16'h0000;
	localparam logic [15:0] SPEC_CERT = 16'h0001;
	localparam logic [15:0] SPEC_COMP = 16'h0002;
	// Supported protocol list, ascending, first entry 00h
	localparam int LIST_N = 3;
	localparam logic [7:0] LIST_VAL [LIST_N] = '{8'h00, 8'h01, 8'h02};
	// List format byte positions
	localparam logic [31:0] LIST_LEN_HI = 32'h0000_0006;
	localparam logic [31:0] LIST_LEN_LO = 32'h0000_0007;
	localparam logic [31:0] LIST_FIRST = 32'h0000_0008;
	// Certificate format byte positions
	localparam logic [31:0] CERT_LEN_HI = 32'h0000_0002;
	localparam logic [31:0] CERT_LEN_LO = 32'h0000_0003;
	localparam logic [31:0] CERT_FIRST = 32'h0000_0004;
	localparam int CERT_DEPTH = 1024;
	localparam int CERT_AW = 10;
	// Compliance format: one descriptor, header fields and body length
	localparam logic [31:0] COMP_FIRST = 32'h0000_0004;
	localparam logic [31:0] COMP_DESC_HDR = 32'h0000_0008;
	localparam logic [15:0] COMP_TYPE_CRYPTO = 16'h0001;
	localparam logic [31:0] COMP_DESC_LEN = 32'h0000_0208;
	localparam logic [31:0] COMP_INFO_LEN = COMP_DESC_HDR + COMP_DESC_LEN;
	// Buffer geometry
	localparam int BUF_W = 9;
	localparam int BUF_DEPTH = 2;

	typedef enum logic [1:0] {FMT_LIST, FMT_CERT, FMT_COMP} spir_fmt_e;
	typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_DONE} spir_state_e;
endpackage : spir_pkg

// [spir_buf.sv]
module spir_buf (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [spir_pkg::BUF_W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [spir_pkg::BUF_W-1:0] out_data
);
	typedef struct packed {
		logic [spir_pkg::BUF_DEPTH-1:0][spir_pkg::BUF_W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} spir_buf_s;

	spir_buf_s st_r;
	spir_buf_s st_nxt;
	logic push;
	logic pop;

	// Handshakes straight from the fill count
	assign in_ready = (st_r.cnt != 2'(spir_pkg::BUF_DEPTH));
	assign out_valid = (st_r.cnt != 2'h0);
	assign out_data = st_r.mem[st_r.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Two entries let the source keep going for one stall
	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wp] = in_data;
			st_nxt.wp = ~st_r.wp;
		end
		if (pop) begin
			st_nxt.rp = ~st_r.rp;
		end
		st_nxt.cnt = st_r.cnt + 2'(push) - 2'(pop);
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : spir_buf

// [spir_responder.sv]
module spir_responder (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_protocol,
	input wire logic [15:0] cmd_specific,
	input wire logic [31:0] cmd_alloc_len,
	input wire logic comp_supported,
	input wire logic [15:0] cert_len,
	input wire logic cert_wr_en,
	input wire logic [spir_pkg::CERT_AW-1:0] cert_wr_addr,
	input wire logic [7:0] cert_wr_data,
	output logic data_valid,
	input wire logic data_ready,
	output logic [7:0] data_byte,
	output logic data_last,
	output logic done,
	output logic done_illegal
);
	typedef struct packed {
		spir_pkg::spir_state_e state;
		spir_pkg::spir_fmt_e fmt;
		logic [31:0] idx;
		logic [31:0] count;
		logic [15:0] clen;
		logic done;
		logic illegal;
	} spir_st_s;

	spir_st_s st_r;
	spir_st_s st_nxt;
	logic [7:0] cert_mem [spir_pkg::CERT_DEPTH];
	logic [7:0] cert_byte;
	logic [7:0] cur_byte;
	logic [31:0] cert_off;
	logic buf_in_valid;
	logic buf_in_ready;
	logic cur_last;
	logic [spir_pkg::BUF_W-1:0] buf_out;

	// Full response length before truncation
	function automatic logic [31:0] resp_len(input spir_pkg::spir_fmt_e f,
		input logic [15:0] cl);
		case (f)
			spir_pkg::FMT_LIST: resp_len = spir_pkg::LIST_FIRST + 32'(spir_pkg::LIST_N);
			spir_pkg::FMT_CERT: resp_len = spir_pkg::CERT_FIRST + 32'(cl);
			spir_pkg::FMT_COMP: resp_len = spir_pkg::COMP_FIRST + spir_pkg::COMP_INFO_LEN;
			default: resp_len = 32'h0;
		endcase
	endfunction : resp_len

	// Smaller of two lengths
	function automatic logic [31:0] min32(input logic [31:0] a, input logic [31:0] b);
		min32 = (a < b) ? a : b;
	endfunction : min32

	// Byte of a big-endian 32-bit field, position 0 is the top byte
	function automatic logic [7:0] be_byte(input logic [31:0] w, input logic [1:0] pos);
		be_byte = 8'(w >> (5'h18 - {pos, 3'h0}));
	endfunction : be_byte

	// Descriptor fields sit at fixed offsets from the first descriptor
	localparam logic [31:0] DESC_TYPE_HI = spir_pkg::COMP_FIRST;
	localparam logic [31:0] DESC_TYPE_LO = spir_pkg::COMP_FIRST + 32'h0000_0001;
	localparam logic [31:0] DESC_LEN_AT = spir_pkg::COMP_FIRST + 32'h0000_0004;

	// Certificate store, written by firmware
	// X.509 payload bytes
	always_ff @(posedge clock) begin
		if (cert_wr_en) begin
			cert_mem[cert_wr_addr] <= cert_wr_data;
		end
	end

	// Plain read keeps one byte per cycle; offsets past the length are masked below
	assign cert_off = st_r.idx - spir_pkg::CERT_FIRST;
	assign cert_byte = cert_mem[cert_off[spir_pkg::CERT_AW-1:0]];

	// Byte generator; anything not named below is zero
	always_comb begin
		cur_byte = 8'h00;
		case (st_r.fmt)
			spir_pkg::FMT_LIST: begin
				if (st_r.idx == spir_pkg::LIST_LEN_LO) begin
					cur_byte = 8'(spir_pkg::LIST_N);
				end else if (st_r.idx >= spir_pkg::LIST_FIRST &&
					st_r.idx < spir_pkg::LIST_FIRST + 32'(spir_pkg::LIST_N)) begin
					cur_byte = spir_pkg::LIST_VAL[st_r.idx - spir_pkg::LIST_FIRST];
				end
			end
			spir_pkg::FMT_CERT: begin
				if (st_r.idx == spir_pkg::CERT_LEN_HI) begin
					cur_byte = st_r.clen[15:8];
				end else if (st_r.idx == spir_pkg::CERT_LEN_LO) begin
					cur_byte = st_r.clen[7:0];
				end else if (st_r.idx >= spir_pkg::CERT_FIRST &&
					st_r.idx < spir_pkg::CERT_FIRST + 32'(st_r.clen)) begin
					cur_byte = cert_byte;
				end
			end
			spir_pkg::FMT_COMP: begin
				if (st_r.idx < spir_pkg::COMP_FIRST) begin
					cur_byte = be_byte(spir_pkg::COMP_INFO_LEN, st_r.idx[1:0]);
				end else if (st_r.idx == DESC_TYPE_HI) begin
					cur_byte = spir_pkg::COMP_TYPE_CRYPTO[15:8];
				end else if (st_r.idx == DESC_TYPE_LO) begin
					cur_byte = spir_pkg::COMP_TYPE_CRYPTO[7:0];
				end else if (st_r.idx >= DESC_LEN_AT &&
					st_r.idx < spir_pkg::COMP_FIRST + spir_pkg::COMP_DESC_HDR) begin
					cur_byte = be_byte(spir_pkg::COMP_DESC_LEN, st_r.idx[1:0]);
				end
			end
			default: cur_byte = 8'h00;
		endcase
	end

	assign cur_last = (st_r.idx == st_r.count - 32'h1);
	assign buf_in_valid = (st_r.state == spir_pkg::ST_SEND);
	assign cmd_ready = (st_r.state == spir_pkg::ST_IDLE);

	// Command sequencer
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		case (st_r.state)
			spir_pkg::ST_IDLE: begin
				if (cmd_valid) begin
					st_nxt.idx = 32'h0;
					st_nxt.illegal = 1'b0;
					// Clamp so reads never leave the store
					st_nxt.clen = (cert_len > 16'(spir_pkg::CERT_DEPTH)) ?
						16'(spir_pkg::CERT_DEPTH) : cert_len;
					if (cmd_protocol != spir_pkg::PROTO_INFO) begin
						st_nxt.illegal = 1'b1;
					end else if (cmd_specific == spir_pkg::SPEC_LIST) begin
						st_nxt.fmt = spir_pkg::FMT_LIST;
					end else if (cmd_specific == spir_pkg::SPEC_CERT) begin
						st_nxt.fmt = spir_pkg::FMT_CERT;
					end else if (cmd_specific == spir_pkg::SPEC_COMP && comp_supported) begin
						st_nxt.fmt = spir_pkg::FMT_COMP;
					end else begin
						st_nxt.illegal = 1'b1;
					end
					st_nxt.count = min32(cmd_alloc_len, resp_len(st_nxt.fmt, st_nxt.clen));
					if (st_nxt.illegal || st_nxt.count == 32'h0) begin
						st_nxt.state = spir_pkg::ST_DONE;
					end else begin
						st_nxt.state = spir_pkg::ST_SEND;
					end
				end
			end
			spir_pkg::ST_SEND: begin
				// Buffer back-pressure holds the index
				if (buf_in_ready) begin
					st_nxt.idx = st_r.idx + 32'h1;
					if (cur_last) begin
						st_nxt.state = spir_pkg::ST_DONE;
					end
				end
			end
			spir_pkg::ST_DONE: begin
				st_nxt.done = 1'b1;
				st_nxt.state = spir_pkg::ST_IDLE;
			end
			default: st_nxt.state = spir_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Completion comes after the last byte enters the buffer
	assign done = st_r.done;
	assign done_illegal = st_r.done && st_r.illegal;

	spir_buf u_buf (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data({cur_last, cur_byte}),
		.out_valid(data_valid),
		.out_ready(data_ready),
		.out_data(buf_out)
	);

	assign data_byte = buf_out[7:0];
	assign data_last = buf_out[8];
endmodule : spir_responder

// [spir_responder_properties.sv]
module spir_chk (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] cmd_protocol,
	input wire logic [15:0] cmd_specific,
	input wire logic [31:0] cmd_alloc_len,
	input wire logic comp_supported,
	input wire logic data_valid,
	input wire logic data_ready,
	input wire logic [7:0] data_byte,
	input wire logic data_last,
	input wire logic done,
	input wire logic done_illegal
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	logic take;
	logic legal;
	// Command accepted, and whether its selector is one we answer
	assign take = cmd_valid && cmd_ready;
	assign legal = cmd_protocol == 8'h00 && (cmd_specific < 16'h0002 || comp_supported
		&& cmd_specific == 16'h0002);
	illegal_with_done_a: assert property (done_illegal |-> done)
		else $error("illegal flag without done");
	done_pulse_a: assert property (done |=> !done)
		else $error("done longer than one cycle");
	busy_refuse_a: assert property (take |=> !cmd_ready)
		else $error("command taken while busy");
	done_idle_a: assert property (done |-> cmd_ready)
		else $error("not idle at done");
	bad_code_a: assert property (take && cmd_protocol == 8'h00 && cmd_specific > 16'h0002
		|-> ##2 done && done_illegal) else $error("reserved code not refused");
	refuse_time_a: assert property (take && !legal |-> ##2 done && done_illegal)
		else $error("refusal late or missing");
	zero_alloc_a: assert property (take && legal && cmd_alloc_len == 32'h0
		|-> ##2 done && !done_illegal) else $error("zero length not ended");
	data_start_a: assert property (take && legal && cmd_alloc_len != 32'h0
		|-> ##[1:8] data_valid) else $error("no first byte");
	// Receiver stall must not drop or alter the waiting byte
	stall_hold_a: assert property (data_valid && !data_ready |=> data_valid
		&& $stable(data_byte) && $stable(data_last)) else $error("byte changed in stall");
endmodule : spir_chk

bind spir_responder spir_chk spir_chk_i (.*);

// [spir_host_model.sv]
module spir_host_model (
	input wire logic clock,
	input wire logic stall,
	input wire logic data_valid,
	output logic data_ready,
	input wire logic [7:0] data_byte,
	input wire logic data_last
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] rx_q[$];
	logic slow_r = 1'b0;
	// Slow receiver accepts every other cycle, changing off the sampling edge
	always @(negedge clock) slow_r <= ~slow_r;
	assign data_ready = ~stall | slow_r;
	// Keep each accepted byte with its last mark for the bench
	always @(posedge clock) if (data_valid && data_ready) rx_q.push_back({data_last, data_byte});
endmodule : spir_host_model

// [spir_responder_tb.sv]
module spir_responder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, sys_rst = 1, cmd_valid = 0, comp_supported = 0, cert_wr_en = 0, stall = 0;
	logic [7:0] cmd_protocol = 8'h00, cert_wr_data = 8'h00, data_byte;
	logic [15:0] cmd_specific = 16'h0000, cert_len = 16'h0000;
	logic [31:0] cmd_alloc_len = 32'h0;
	logic [spir_pkg::CERT_AW-1:0] cert_wr_addr = '0;
	logic cmd_ready, data_valid, data_ready, data_last, done, done_illegal, ill_got, seen;
	logic [7:0] exp_q[$];
	int mismatches = 0, checked = 0;
	spir_responder spir_responder_i (.*);
	spir_host_model spir_host_model_i (.*);
	initial forever #4 clock = ~clock;
	task end_of_test;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: flag", $time);
		end
	endtask : cmp_bit
	task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: byte %h not %h", $time, got, exp);
		end
	endtask : cmp_byte
	// Whole response against expectation, last mark on the final byte only
	task cmp_resp;
		int n;
		n = spir_host_model_i.rx_q.size();
		cmp_bit(n == exp_q.size(), 1'b1);
		for (int i = 0; i < n && i < exp_q.size(); i++) begin
			cmp_byte(spir_host_model_i.rx_q[i][7:0], exp_q[i]);
			cmp_bit(spir_host_model_i.rx_q[i][8], i == n - 1);
		end
	endtask : cmp_resp
	// One command, held a cycle while idle, then wait for done and drain
	task run(input logic [7:0] p, input logic [15:0] s, input logic [31:0] a);
		int i;
		spir_host_model_i.rx_q.delete();
		while (cmd_ready !== 1'b1) @(negedge clock);
		{cmd_protocol, cmd_specific, cmd_alloc_len, cmd_valid} = {p, s, a, 1'b1};
		@(negedge clock);
		cmd_valid = 0;
		for (i = 0; i < 700 && done !== 1'b1; i++) @(negedge clock);
		{seen, ill_got} = {done, done_illegal};
		for (i = 0; i < 60 && data_valid === 1'b1; i++) @(negedge clock);
		cmp_bit(seen, 1'b1);
	endtask : run
	// Reset in mid-response leaves the block idle and quiet, then a fresh list
	task t_reset;
		stall = 1;
		{cmd_protocol, cmd_specific, cmd_alloc_len, cmd_valid} = {8'h00, 16'h0000, 32'h64, 1'b1};
		@(negedge clock);
		cmd_valid = 0;
		repeat (3) @(negedge clock);
		sys_rst = 1;
		@(negedge clock);
		cmp_bit(data_valid, 1'b0);
		cmp_bit(cmd_ready, 1'b1);
		cmp_bit(done, 1'b0);
		sys_rst = 0;
		exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h01, 8'h02};
		run(8'h00, 16'h0000, 32'h64);
		cmp_resp();
		stall = 0;
	endtask : t_reset
	task t_list;
		stall = 1;
		exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h01, 8'h02};
		run(8'h00, 16'h0000, 32'h64);
		cmp_bit(ill_got, 1'b0);
		cmp_resp();
		run(8'h00, 16'h0000, 32'h9);
		exp_q = exp_q[0:8];
		cmp_resp();
		stall = 0;
	endtask : t_list
	task t_cert;
		for (int i = 0; i < 3; i++) begin
			{cert_wr_en, cert_wr_addr, cert_wr_data} = {1'b1, 10'(i), 8'hA1 + 8'(i * 17)};
			@(negedge clock);
		end
		{cert_wr_en, cert_len} = {1'b0, 16'h0003};
		exp_q = '{8'h00, 8'h00, 8'h00, 8'h03, 8'hA1, 8'hB2, 8'hC3};
		run(8'h00, 16'h0001, 32'h40);
		cmp_resp();
		cert_len = 16'h0000;
		exp_q = '{8'h00, 8'h00, 8'h00, 8'h00};
		run(8'h00, 16'h0001, 32'h40);
		cmp_resp();
	endtask : t_cert
	task t_comp;
		comp_supported = 1;
		exp_q = '{8'h00, 8'h00, 8'h02, 8'h10, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h08};
		run(8'h00, 16'h0002, 32'hC);
		cmp_resp();
		exp_q = {};
		run(8'h00, 16'h0002, 32'h0);
		cmp_bit(ill_got, 1'b0);
		cmp_resp();
		comp_supported = 0;
	endtask : t_comp
	// Foreign protocol, reserved codes and the unsupported optional code
	task t_illegal;
		logic [23:0] cases [4] = '{24'h01_0000, 24'h00_0003, 24'h00_FFFF, 24'h00_0002};
		exp_q = {};
		foreach (cases[k]) begin
			run(cases[k][23:16], cases[k][15:0], 32'h40);
			cmp_bit(ill_got, 1'b1);
			cmp_resp();
		end
	endtask : t_illegal
	initial begin
		repeat (20) @(negedge clock);
		sys_rst = 0;
		t_list();
		t_reset();
		t_cert();
		t_comp();
		t_illegal();
		end_of_test();
	end
	// Whole run needs under two hundred cycles; far beyond that is a hang
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		end_of_test();
	end
endmodule : spir_responder_tb
